/* pkg/timer_pkg.sv */
// timer time base and channel 0 value: register map, field layout, reset values
// assumes a 32-bit APB slave with byte addresses in the low eight address bits
package timer_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CNT_OFS = 8'h24;
    localparam logic [7:0] PSC_OFS = 8'h28;
    localparam logic [7:0] CAR_OFS = 8'h2C;
    localparam logic [7:0] REP_OFS = 8'h30;
    localparam logic [7:0] CH0_OFS = 8'h34;
    localparam int CNT_W = 16;
    localparam int REP_W = 8;
    localparam int CTRL_W = 3;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_IN_BIT = 1;
    localparam int CTRL_SHD_BIT = 2;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [7:0] REP_RST = 8'h00;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

/* pkg/ch_if.sv */
// carrier between the time base and the channel 0 value unit
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface ch_if;
    logic [15:0] count;
    logic update;
    logic input_mode;
    logic shadow_en;
    logic capture;
    logic wr_en;
    logic [15:0] wr_data;
    logic [15:0] value;
    logic match;
    modport main (output count, update, input_mode, shadow_en, capture, wr_en, wr_data, input value, match);
    modport chan (input count, update, input_mode, shadow_en, capture, wr_en, wr_data, output value, match);
endinterface

/* verilog/prescale_counter.sv */
// prescaler: emits one tick every div+1 enabled kernel cycles
// assumes div comes from the active copy, stable between update events
`timescale 1ns/1ns
module prescale_counter #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [W-1:0] div,
    // tick out
    output logic tick
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // ==========================================
    // divider
    always_comb begin
        next_cnt = cnt;
        if (restart || (run && cnt >= div)) begin
            next_cnt = '0;
        end else if (run) begin
            next_cnt = cnt + 1'b1;
        end
    end

    assign tick = run && !restart && cnt >= div;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (ce) begin
            cnt <= next_cnt;
        end
    end

    // ==========================================
    // checks
    div_step_a: assert property (@(posedge clk) disable iff (rst)
        ce && run && !restart && cnt < div |=> cnt == $past(cnt) + 1'b1)
        else $error("prescaler did not advance");
    div_wrap_a: assert property (@(posedge clk) disable iff (rst)
        ce && tick |=> cnt == '0)
        else $error("prescaler did not wrap after tick");
endmodule

/* verilog/ch0_value_unit.sv */
// channel 0 capture/compare value with optional active copy
// assumes capture is a one-cycle pulse already synchronised
`timescale 1ns/1ns
module ch0_value_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link to the time base
    ch_if.chan bus
);
    logic [15:0] value;
    logic [15:0] active;
    logic match;
    logic [15:0] next_value;
    logic [15:0] next_active;
    logic next_match;

    // ==========================================
    // value, active copy, compare
    always_comb begin
        next_value = value;
        next_active = active;
        if (bus.input_mode) begin
            if (bus.capture) begin
                next_value = bus.count;
            end
        end else if (bus.wr_en) begin
            next_value = bus.wr_data;
        end
        // in input mode writes fall through untouched, the field is read-only
        if (bus.input_mode || !bus.shadow_en || bus.update) begin
            next_active = next_value;
        end
        next_match = !bus.input_mode && bus.count == active;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= timer_pkg::VAL_RST;
            active <= timer_pkg::VAL_RST;
            match <= 1'b0;
        end else if (ce) begin
            value <= next_value;
            active <= next_active;
            match <= next_match;
        end
    end

    assign bus.value = value;
    assign bus.match = match;

    // ==========================================
    // checks
    cap_latch_a: assert property (@(posedge clk) disable iff (rst)
        ce && bus.input_mode && bus.capture |=> value == $past(bus.count))
        else $error("capture did not latch count");
    ro_input_a: assert property (@(posedge clk) disable iff (rst)
        ce && bus.input_mode && !bus.capture |=> value == $past(value))
        else $error("input-mode value changed without capture");
    cmp_match_a: assert property (@(posedge clk) disable iff (rst)
        ce && !bus.input_mode && bus.count == active |=> match)
        else $error("compare match missed");
    shadow_hold_a: assert property (@(posedge clk) disable iff (rst)
        ce && !bus.input_mode && bus.shadow_en && !bus.update |=> active == $past(active))
        else $error("active compare moved between updates");
endmodule

/* verilog/timer_timebase.sv */
// timer time base: APB registers, prescaler, counter, repetition, channel 0
// assumes APB master on I_REF_CLK; I_CAPTURE is an asynchronous pin
`timescale 1ns/1ns
module timer_timebase (
    // clock, reset, enable
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_CLK_EN,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // channel pin
    input wire logic I_CAPTURE,
    // status
    output logic O_UPDATE,
    output logic O_CH0_MATCH,
    output logic [15:0] O_COUNT
);
    logic [2:0] ctrl;
    logic [15:0] count;
    logic [15:0] prescale_divider;
    logic [15:0] psc_active;
    logic [15:0] car;
    logic [7:0] rep;
    logic [7:0] rep_cnt;
    logic update;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cap_meta;
    logic cap_sync;
    logic cap_prev;

    logic [2:0] next_ctrl;
    logic [15:0] next_count;
    logic [15:0] next_psc;
    logic [15:0] next_psc_active;
    logic [15:0] next_car;
    logic [7:0] next_rep;
    logic [7:0] next_rep_cnt;
    logic next_update;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    logic tick;
    logic wrap;
    logic upd_evt;
    logic setup;
    logic wr;
    logic cnt_wr;

    ch_if ch ();

    // ==========================================
    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = a == ofs;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, timer_pkg::CTRL_OFS) || hit(a, timer_pkg::CNT_OFS)
            || hit(a, timer_pkg::PSC_OFS) || hit(a, timer_pkg::CAR_OFS)
            || hit(a, timer_pkg::REP_OFS) || hit(a, timer_pkg::CH0_OFS);
    endfunction

    // ==========================================
    // apb handshake
    // one wait-free access phase: pready is raised by the setup cycle, so
    // every transfer completes at the first access edge
    assign setup = I_PSEL && !I_PENABLE;
    assign wr = I_PSEL && I_PENABLE && pready && I_PWRITE && !pslverr;
    assign cnt_wr = wr && hit(I_PADDR, timer_pkg::CNT_OFS);

    always_comb begin
        next_pready = setup;
        next_pslverr = setup && !mapped(I_PADDR);
        next_prdata = prdata;
        if (setup) begin
            next_prdata = timer_pkg::WORD_ZERO;
            case (I_PADDR)
                timer_pkg::CTRL_OFS: begin
                    next_prdata[timer_pkg::CTRL_W-1:0] = ctrl;
                end
                timer_pkg::CNT_OFS: begin
                    next_prdata[15:0] = count;
                end
                timer_pkg::PSC_OFS: begin
                    next_prdata[15:0] = prescale_divider;
                end
                timer_pkg::CAR_OFS: begin
                    next_prdata[15:0] = car;
                end
                timer_pkg::REP_OFS: begin
                    next_prdata[7:0] = rep;
                end
                timer_pkg::CH0_OFS: begin
                    next_prdata[15:0] = ch.value;
                end
                default: begin
                    next_prdata = timer_pkg::WORD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            prdata <= timer_pkg::WORD_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (I_CLK_EN) begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================
    // software registers
    // only the low bits are stored; reserved bits read back as zero
    always_comb begin
        next_ctrl = ctrl;
        next_psc = prescale_divider;
        next_car = car;
        next_rep = rep;
        if (wr && hit(I_PADDR, timer_pkg::CTRL_OFS)) begin
            next_ctrl = I_PWDATA[timer_pkg::CTRL_W-1:0];
        end
        if (wr && hit(I_PADDR, timer_pkg::PSC_OFS)) begin
            next_psc = I_PWDATA[15:0];
        end
        if (wr && hit(I_PADDR, timer_pkg::CAR_OFS)) begin
            next_car = I_PWDATA[15:0];
        end
        if (wr && hit(I_PADDR, timer_pkg::REP_OFS)) begin
            next_rep = I_PWDATA[7:0];
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl <= timer_pkg::CTRL_RST;
            prescale_divider <= timer_pkg::VAL_RST;
            car <= timer_pkg::VAL_RST;
            rep <= timer_pkg::REP_RST;
        end else if (I_CLK_EN) begin
            ctrl <= next_ctrl;
            prescale_divider <= next_psc;
            car <= next_car;
            rep <= next_rep;
        end
    end

    // ==========================================
    // prescaler
    prescale_counter #(
        .W(timer_pkg::CNT_W)
    ) u_psc (
        .clk(I_REF_CLK),
        .rst(I_RST),
        .ce(I_CLK_EN),
        .run(ctrl[timer_pkg::CTRL_RUN_BIT]),
        .restart(cnt_wr),
        .div(psc_active),
        .tick(tick)
    );

    // ==========================================
    // counter, repetition, update event
    assign wrap = tick && !cnt_wr && count >= car;
    assign upd_evt = wrap && rep_cnt == '0;

    always_comb begin
        next_count = count;
        next_rep_cnt = rep_cnt;
        next_psc_active = psc_active;
        next_update = upd_evt;
        if (cnt_wr) begin
            next_count = I_PWDATA[15:0];
        end else if (wrap) begin
            next_count = '0;
        end else if (tick) begin
            next_count = count + 1'b1;
        end
        if (upd_evt) begin
            next_rep_cnt = rep;
            next_psc_active = prescale_divider;
        end else if (wrap) begin
            next_rep_cnt = rep_cnt - 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            count <= timer_pkg::VAL_RST;
            rep_cnt <= timer_pkg::REP_RST;
            psc_active <= timer_pkg::VAL_RST;
            update <= 1'b0;
        end else if (I_CLK_EN) begin
            count <= next_count;
            rep_cnt <= next_rep_cnt;
            psc_active <= next_psc_active;
            update <= next_update;
        end
    end

    // ==========================================
    // capture pin synchroniser and edge
    // the edge detector looks only at the second and third flops
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            cap_meta <= 1'b0;
            cap_sync <= 1'b0;
            cap_prev <= 1'b0;
        end else if (I_CLK_EN) begin
            cap_meta <= I_CAPTURE;
            cap_sync <= cap_meta;
            cap_prev <= cap_sync;
        end
    end

    // ==========================================
    // channel 0
    assign ch.count = count;
    assign ch.update = upd_evt;
    assign ch.input_mode = ctrl[timer_pkg::CTRL_IN_BIT];
    assign ch.shadow_en = ctrl[timer_pkg::CTRL_SHD_BIT];
    assign ch.capture = cap_sync && !cap_prev;
    assign ch.wr_en = wr && hit(I_PADDR, timer_pkg::CH0_OFS);
    assign ch.wr_data = I_PWDATA[15:0];

    ch0_value_unit u_ch0 (
        .clk(I_REF_CLK),
        .rst(I_RST),
        .ce(I_CLK_EN),
        .bus(ch)
    );

    // ==========================================
    // outputs
    assign O_PRDATA = prdata;
    assign O_PREADY = pready;
    assign O_PSLVERR = pslverr;
    assign O_UPDATE = update;
    assign O_CH0_MATCH = ch.match;
    assign O_COUNT = count;

    // ==========================================
    // checks
    psc_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && !upd_evt |=> psc_active == $past(psc_active))
        else $error("active prescaler changed outside update");
    psc_load_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && upd_evt |=> psc_active == $past(prescale_divider))
        else $error("active prescaler not loaded at update");
    cnt_wrap_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && tick && !cnt_wr && count >= car |=> count == '0)
        else $error("counter did not wrap at reload value");
    rep_down_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && wrap && rep_cnt != '0 |=> rep_cnt == $past(rep_cnt) - 1'b1 && !update)
        else $error("repetition counter step wrong");
    rep_upd_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && wrap && rep_cnt == '0 |=> update && rep_cnt == $past(rep))
        else $error("update event missing at repetition zero");
    cnt_write_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_CLK_EN && cnt_wr |=> count == $past(I_PWDATA[15:0]))
        else $error("counter write not applied");
    reset_clear_a: assert property (@(posedge I_REF_CLK)
        $past(I_RST) && !I_RST |-> psc_active == '0 && count == '0 && rep_cnt == '0)
        else $error("state not cleared by reset");
endmodule

/* dv/timer_timebase_ch0_value_test.sv */
// self-checking bench for the timer time base and channel 0 value registers
// assumes the design answers apb on I_REF_CLK and holds I_CLK_EN high throughout
`timescale 1ns/1ns
module timer_timebase_ch0_value_test;
    // ==========================================================
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic capture = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic update;
    logic match;
    logic [15:0] cnt;
    int n_errors = 0;
    int cmp_count = 0;

    timer_timebase u_dut (
        .I_REF_CLK(ref_clk),
        .I_RST(rst),
        .I_CLK_EN(clk_en),
        .I_PSEL(psel),
        .I_PENABLE(penable),
        .I_PWRITE(pwrite),
        .I_PADDR(paddr),
        .I_PWDATA(pwdata),
        .O_PRDATA(prdata),
        .O_PREADY(pready),
        .O_PSLVERR(pslverr),
        .I_CAPTURE(capture),
        .O_UPDATE(update),
        .O_CH0_MATCH(match),
        .O_COUNT(cnt)
    );

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // shared tasks
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    // signals held from setup through the edge where pready is sampled high;
    // only the watchdog ends a wait that never sees pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        check(name, r, exp);
        check("pslverr", e, 1'b0);
    endtask

    task automatic wait_update(output int c);
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (update !== 1'b1 && c < 3000);
    endtask

    task automatic wait_match();
        logic prev;
        int n;
        n = 0;
        prev = match;
        @(negedge ref_clk);
        while (!(match === 1'b1 && prev !== 1'b1) && n < 3000) begin
            prev = match;
            @(negedge ref_clk);
            n++;
        end
    endtask

    // cycles between two successive count changes
    task automatic measure_tick(output int c);
        logic [15:0] last;
        for (int k = 0; k < 2; k++) begin
            c = 0;
            last = cnt;
            do begin
                @(negedge ref_clk);
                c++;
            end while (cnt === last && c < 100);
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] ofs [4];
        logic [31:0] msk [4];
        logic [31:0] r;
        logic e;
        ofs = '{timer_pkg::PSC_OFS, timer_pkg::CAR_OFS, timer_pkg::REP_OFS, timer_pkg::CH0_OFS};
        msk = '{32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_00FF, 32'h0000_FFFF};
        rd_chk("ctrl reset", timer_pkg::CTRL_OFS, 32'h0000_0000);
        rd_chk("count reset", timer_pkg::CNT_OFS, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            rd_chk("reg reset", ofs[i], 32'h0000_0000);
            wr(ofs[i], 32'h0000_FFFF);
            rd_chk("reg width", ofs[i], msk[i]);
            wr(ofs[i], 32'h0000_0000);
        end
        apb(8'h40, 1'b0, 32'h0000_0000, r, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", r, 32'h0000_0000);
    endtask

    task automatic t_wrap();
        int c;
        wr(timer_pkg::CAR_OFS, 32'h0000_0002);
        wr(timer_pkg::REP_OFS, 32'h0000_0001);
        wr(timer_pkg::CNT_OFS, 32'h0000_0005);
        rd_chk("count write", timer_pkg::CNT_OFS, 32'h0000_0005);
        wr(timer_pkg::CTRL_OFS, 32'h0000_0001);
        measure_tick(c);
        check("divide by one", c, 1);
        wait_update(c);
        wait_update(c);
        check("update period", c, 6);
        repeat (6) begin
            @(negedge ref_clk);
            check("count within reload", cnt <= 16'h0002, 1'b1);
        end
    endtask

    task automatic t_compare();
        int c;
        wr(timer_pkg::CTRL_OFS, 32'h0000_0000);
        wr(timer_pkg::CAR_OFS, 32'h0000_0009);
        wr(timer_pkg::REP_OFS, 32'h0000_0000);
        wr(timer_pkg::CH0_OFS, 32'h0000_0005);
        wr(timer_pkg::CNT_OFS, 32'h0000_0000);
        wr(timer_pkg::CTRL_OFS, 32'h0000_0001);
        wait_match();
        check("match direct", cnt, 16'h0006);
        // stopped so no update can slip in before the new value is checked
        wr(timer_pkg::CTRL_OFS, 32'h0000_0004);
        wr(timer_pkg::CH0_OFS, 32'h0000_0008);
        rd_chk("compare readback", timer_pkg::CH0_OFS, 32'h0000_0008);
        wr(timer_pkg::CNT_OFS, 32'h0000_0000);
        wr(timer_pkg::CTRL_OFS, 32'h0000_0005);
        wait_match();
        check("match old active", cnt, 16'h0006);
        wait_update(c);
        wait_match();
        check("match after update", cnt, 16'h0009);
    endtask

    task automatic t_capture();
        wr(timer_pkg::CTRL_OFS, 32'h0000_0002);
        wr(timer_pkg::CAR_OFS, 32'h0000_FFFF);
        wr(timer_pkg::CNT_OFS, 32'h0000_1234);
        @(posedge ref_clk);
        capture <= 1'b1;
        repeat (5) @(posedge ref_clk);
        capture <= 1'b0;
        rd_chk("captured value", timer_pkg::CH0_OFS, 32'h0000_1234);
        wr(timer_pkg::CH0_OFS, 32'h0000_AAAA);
        rd_chk("input read only", timer_pkg::CH0_OFS, 32'h0000_1234);
    endtask

    task automatic t_prescale();
        int c;
        wr(timer_pkg::CTRL_OFS, 32'h0000_0000);
        wr(timer_pkg::CAR_OFS, 32'h0000_00FF);
        wr(timer_pkg::CNT_OFS, 32'h0000_0000);
        wr(timer_pkg::CTRL_OFS, 32'h0000_0001);
        wait_update(c);
        wr(timer_pkg::PSC_OFS, 32'h0000_0002);
        rd_chk("prescale readback", timer_pkg::PSC_OFS, 32'h0000_0002);
        measure_tick(c);
        check("prescale held", c, 1);
        wait_update(c);
        measure_tick(c);
        check("prescale active", c, 3);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_wrap();
        t_compare();
        t_capture();
        t_prescale();
        print_verdict();
    end

    // generous margin over the several hundred cycles the scenarios need
    initial begin
        #1_000_000;
        n_errors++;
        print_verdict();
    end
endmodule
